// ### rtl/dadc_pkg.sv
// Constants shared by the dual converter output control.
// Assumes every user imports the whole package.
package dadc_pkg;
  // ==========================================================
  // Result word
  localparam int RES_W = 12;
  localparam int RES_MSB = 11;
  localparam logic [11:0] RES_RST = 12'h000;

  // ==========================================================
  // Three-level strap codes after the pad comparators
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_MID = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  localparam logic [1:0] STRAP_RST = 2'h0;

  // ==========================================================
  // Conversion clock figure the far side must keep to, in MHz
  localparam int CONV_CLK_MHZ = 80;
  localparam int SYS_CLK_MHZ = 20;
endpackage : dadc_pkg

// ### rtl/dadc_fmt.sv
// Number format stage for one channel result.
// Assumes the incoming code is offset binary.
`timescale 1ns/1ps
`default_nettype none
module dadc_fmt
  import dadc_pkg::*;
(
  // Code in
  input wire logic [RES_W-1:0] code_in,
  input wire logic twos_sel,
  // Code out
  output logic [RES_W-1:0] code_out
);
  // ==========================================================
  // Offset binary to two's complement is an MSB flip
  always_comb begin
    code_out = code_in;
    code_out[RES_MSB] = code_in[RES_MSB] ^ twos_sel;
  end
endmodule // dadc_fmt
`default_nettype wire

// ### rtl/dadc_out_ctrl.sv
// Output control of a dual 12-bit converter: strap decode, format,
// per-channel enables and the ready strobe.
// Assumes a core delivering offset binary codes on the system clock;
// pins and the conversion clock arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none
module dadc_out_ctrl
  import dadc_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Conversion core
  input wire logic conv_clk_in,
  input wire logic [RES_W-1:0] core_a_code,
  input wire logic [RES_W-1:0] core_b_code,
  // Control pins
  input wire logic [1:0] format_or_strobe_strap,
  input wire logic chan_a_enable_or_format,
  input wire logic chan_b_enable_or_ready_strobe_i,
  output logic chan_b_enable_or_ready_strobe_o,
  output logic chan_b_enable_or_ready_strobe_oe,
  input wire logic power_down_in,
  // Result buses
  output logic [RES_W-1:0] chan_a_result,
  output logic chan_a_result_oe,
  output logic [RES_W-1:0] chan_b_result,
  output logic chan_b_result_oe
);
  // ==========================================================
  // State
  typedef struct packed {
    logic cclk_m;
    logic cclk_s;
    logic cclk_p;
    logic [1:0] strap_m;
    logic [1:0] strap_s;
    logic ena_m;
    logic ena_s;
    logic enb_m;
    logic enb_s;
    logic pwrdn_m;
    logic pwrdn_s;
    logic [RES_W-1:0] res_a;
    logic [RES_W-1:0] res_b;
    logic oe_a;
    logic oe_b;
    logic strobe;
    logic strobe_oe;
  } dadc_state_s;

  dadc_state_s st_q;
  dadc_state_s st_d;
  logic conv_rise;
  logic strobe_mode;
  logic twos_sel;
  logic [RES_W-1:0] fmt_a;
  logic [RES_W-1:0] fmt_b;

  function automatic logic is_strobe_mode(input logic [1:0] strap);
    return strap == STRAP_MID;
  endfunction

  // ==========================================================
  // Mode and format decode
  assign conv_rise = st_q.cclk_s & ~st_q.cclk_p;
  assign strobe_mode = is_strobe_mode(st_q.strap_s);
  // Any code other than mid or low counts as a full high level
  assign twos_sel = strobe_mode ? st_q.ena_s : (st_q.strap_s != STRAP_LOW);

  dadc_fmt u_fmt_a (
    .code_in(core_a_code),
    .twos_sel(twos_sel),
    .code_out(fmt_a)
  );

  dadc_fmt u_fmt_b (
    .code_in(core_b_code),
    .twos_sel(twos_sel),
    .code_out(fmt_b)
  );

  // ==========================================================
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.cclk_m = conv_clk_in;
    st_d.cclk_s = st_q.cclk_m;
    st_d.cclk_p = st_q.cclk_s;
    st_d.strap_m = format_or_strobe_strap;
    st_d.strap_s = st_q.strap_m;
    st_d.ena_m = chan_a_enable_or_format;
    st_d.ena_s = st_q.ena_m;
    st_d.enb_m = chan_b_enable_or_ready_strobe_i;
    st_d.enb_s = st_q.enb_m;
    st_d.pwrdn_m = power_down_in;
    st_d.pwrdn_s = st_q.pwrdn_m;
    // Power-down freezes the words rather than floating them
    if (conv_rise && !st_q.pwrdn_s) begin
      st_d.res_a = fmt_a;
      st_d.res_b = fmt_b;
    end
    if (strobe_mode) begin
      st_d.oe_a = 1'h1;
      st_d.oe_b = 1'h1;
      st_d.strobe_oe = 1'h1;
      // Low while the clock is high, so a new word meets the falling edge
      st_d.strobe = ~st_q.cclk_s & ~st_q.pwrdn_s;
    end else begin
      st_d.oe_a = ~st_q.ena_s;
      st_d.oe_b = ~st_q.enb_s;
      st_d.strobe_oe = 1'h0;
      st_d.strobe = 1'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
      st_q.strap_m <= STRAP_RST;
      st_q.strap_s <= STRAP_RST;
      st_q.res_a <= RES_RST;
      st_q.res_b <= RES_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  assign chan_a_result = st_q.res_a;
  assign chan_b_result = st_q.res_b;
  assign chan_a_result_oe = st_q.oe_a;
  assign chan_b_result_oe = st_q.oe_b;
  assign chan_b_enable_or_ready_strobe_o = st_q.strobe;
  assign chan_b_enable_or_ready_strobe_oe = st_q.strobe_oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  logic take;
  assign take = conv_rise && !st_q.pwrdn_s;

  a_hold_between: assert property (
    !take |=> $stable(chan_a_result) && $stable(chan_b_result))
    else $error("result changed without a conversion edge");

  a_strobe_pin_dir: assert property (
    strobe_mode |=> chan_b_enable_or_ready_strobe_oe)
    else $error("strobe pin not driven in strobe mode");

  a_both_driven: assert property (
    strobe_mode |=> chan_a_result_oe && chan_b_result_oe)
    else $error("result bus floated in strobe mode");

  a_low_offset: assert property (
    take && st_q.strap_s == STRAP_LOW
      |=> chan_a_result == $past(core_a_code) && !chan_b_enable_or_ready_strobe_oe)
    else $error("low strap not offset binary");

  a_high_twos: assert property (
    take && st_q.strap_s == STRAP_HIGH
      |=> chan_b_result[RES_MSB] != $past(core_b_code[RES_MSB])
        && chan_b_result[RES_MSB-1:0] == $past(core_b_code[RES_MSB-1:0]))
    else $error("high strap not two's complement");

  a_strobe_format: assert property (
    take && strobe_mode
      |=> chan_a_result[RES_MSB] == ($past(core_a_code[RES_MSB]) ^ $past(st_q.ena_s)))
    else $error("format pin ignored in strobe mode");

  a_chan_a_hiz: assert property (
    !strobe_mode |=> chan_a_result_oe == !$past(st_q.ena_s))
    else $error("channel A enable wrong");

  a_chan_b_hiz: assert property (
    !strobe_mode |=> chan_b_result_oe == !$past(st_q.enb_s))
    else $error("channel B enable wrong");

  a_data_on_fall: assert property (
    take && strobe_mode ##1 chan_b_enable_or_ready_strobe_oe
      |-> !chan_b_enable_or_ready_strobe_o ##1 !chan_b_enable_or_ready_strobe_o)
    else $error("data update not on strobe fall");

  // The strobe is the conversion clock inverted, three edges behind the pin
  a_strobe_rate: assert property (
    strobe_mode && !st_q.pwrdn_s
      |=> chan_b_enable_or_ready_strobe_o != $past(conv_clk_in, 3))
    else $error("strobe not following conversion clock");

  a_power_down: assert property (
    st_q.pwrdn_s |=> $stable(chan_a_result) && $stable(chan_b_result))
    else $error("result moved in power-down");

  a_sleep_strobe_low: assert property (
    strobe_mode && st_q.pwrdn_s |=> !chan_b_enable_or_ready_strobe_o)
    else $error("strobe toggling in power-down");

  a_enable_no_strobe: assert property (
    !strobe_mode |=> !chan_b_enable_or_ready_strobe_o && !chan_b_enable_or_ready_strobe_oe)
    else $error("strobe active in enable mode");

  c_strobe_sample: cover property (take && strobe_mode);
  c_format_twos: cover property (take && strobe_mode && st_q.ena_s);
  c_enable_split: cover property (!strobe_mode && chan_a_result_oe && !chan_b_result_oe);
  c_power_down: cover property (conv_rise && st_q.pwrdn_s);
endmodule // dadc_out_ctrl
`default_nettype wire

// ### tb/dadc_capture.sv
// Capture logic model: latches both result words one clock edge after the strobe falls.
// Assumes it shares the system clock with the output control.
`timescale 1ns/1ps
`default_nettype none
module dadc_capture
  import dadc_pkg::*;
(
  // Clock
  input wire logic clock,
  // Device side
  input wire logic ready_strobe,
  input wire logic [RES_W-1:0] word_a,
  input wire logic [RES_W-1:0] word_b,
  // Captured pair
  output var logic [RES_W-1:0] cap_a,
  output var logic [RES_W-1:0] cap_b,
  output var int cap_cnt
);
  logic strobe_q = 1'h0;
  int cnt_q = 0;
  assign cap_cnt = cnt_q;
  // ==========================================================
  // Capture
  // Words are only trusted one edge after the strobe fell
  always @(posedge clock) begin
    strobe_q <= ready_strobe;
    if (strobe_q && !ready_strobe) begin
      cap_a <= word_a;
      cap_b <= word_b;
      cnt_q <= cnt_q + 1;
    end
  end
endmodule // dadc_capture
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the dual converter output control.
// Assumes the capture model and the design package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dadc_pkg::*;
  logic clock = 1'h0;
  logic srst = 1'h1;
  logic conv = 1'h0;
  logic [RES_W-1:0] code_a = 12'h000;
  logic [RES_W-1:0] code_b = 12'h000;
  logic [1:0] strap = STRAP_LOW;
  logic pin_a = 1'h0;
  logic drv_b = 1'h0;
  logic pwr_dn = 1'h0;
  wire logic pin_b;
  logic strb, strb_oe, oe_a, oe_b;
  logic [RES_W-1:0] res_a, res_b, cap_a, cap_b;
  int cap_cnt;
  int error_cnt = 0;
  int n_tests = 0;
  always #25 clock = ~clock;
  // Shared pin: the device drives it in strobe mode, the bench otherwise
  assign pin_b = strb_oe ? strb : drv_b;
  dadc_out_ctrl dut_u (.clock(clock), .srst(srst), .conv_clk_in(conv),
    .core_a_code(code_a), .core_b_code(code_b), .format_or_strobe_strap(strap),
    .chan_a_enable_or_format(pin_a), .chan_b_enable_or_ready_strobe_i(pin_b),
    .chan_b_enable_or_ready_strobe_o(strb), .chan_b_enable_or_ready_strobe_oe(strb_oe),
    .power_down_in(pwr_dn), .chan_a_result(res_a), .chan_a_result_oe(oe_a),
    .chan_b_result(res_b), .chan_b_result_oe(oe_b));
  dadc_capture cap_u (.clock(clock), .ready_strobe(pin_b), .word_a(res_a),
    .word_b(res_b), .cap_a(cap_a), .cap_b(cap_b), .cap_cnt(cap_cnt));
  // ==========================================================
  // Helpers
  task automatic go(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [RES_W-1:0] got, input logic [RES_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Clock phases of four system cycles stay above the two-cycle minimum
  task automatic convert(input logic [RES_W-1:0] a, input logic [RES_W-1:0] b);
    code_a = a;
    code_b = b;
    conv = 1'h1;
    go(4);
    conv = 1'h0;
    go(4);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_strobe(input logic fmt);
    int c0;
    logic [RES_W-1:0] msb;
    strap = STRAP_MID;
    pin_a = fmt;
    drv_b = 1'h1;
    go(4);
    c0 = cap_cnt;
    convert(12'h123, 12'hABC);
    msb = fmt ? 12'h800 : 12'h000;
    chk({9'h000, strb_oe, oe_a, oe_b}, 12'h007);
    chk(cap_a, 12'h123 ^ msb);
    chk(cap_b, 12'hABC ^ msb);
    chk(12'(cap_cnt - c0), 12'h001);
  endtask
  task automatic t_enable(input logic [1:0] lvl, input logic ea, input logic eb);
    logic [RES_W-1:0] msb;
    strap = lvl;
    pin_a = ea;
    drv_b = eb;
    go(4);
    convert(12'h5A5, 12'h03C);
    msb = (lvl == STRAP_LOW) ? 12'h000 : 12'h800;
    chk(res_a, 12'h5A5 ^ msb);
    chk(res_b, 12'h03C ^ msb);
    chk({10'h000, oe_a, oe_b}, {10'h000, ~ea, ~eb});
    chk({11'h000, strb_oe | strb}, 12'h000);
  endtask
  task automatic t_power_down;
    pwr_dn = 1'h1;
    go(4);
    convert(12'hFFF, 12'h7FF);
    chk(res_a, 12'hDA5);
    pwr_dn = 1'h0;
    go(4);
    convert(12'h001, 12'h802);
    chk(res_b, 12'h002);
    // Strobe mode entered already powered down: no word taken, strobe held low
    strap = STRAP_MID;
    pwr_dn = 1'h1;
    convert(12'h3C3, 12'h3C3);
    chk({11'h000, strb}, 12'h000);
    chk(res_a, 12'h801);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    go(4);
    // Reset keeps every word and pin drive quiet
    chk(res_a, 12'h000);
    chk(res_b, 12'h000);
    chk({8'h00, strb, strb_oe, oe_a, oe_b}, 12'h000);
    srst = 1'h0;
    go(1);
    // Enable pins idle low, and the cleared synchronisers agree
    chk({10'h000, oe_a, oe_b}, 12'h003);
    t_strobe(1'h0);
    t_strobe(1'h1);
    t_enable(STRAP_LOW, 1'h0, 1'h1);
    t_enable(STRAP_HIGH, 1'h1, 1'h0);
    t_enable(STRAP_HIGH, 1'h0, 1'h0);
    // Code 3 from the pad comparators counts as a full high level
    t_enable(~STRAP_LOW, 1'h0, 1'h1);
    t_power_down;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
